// >>> rtl/gp_tlbi.sv
// protection-table tlb store with invalidation engine and walk gate
// assumes an avalon-mm master, a walker and peer tlbs on ref_clk
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gp_tlbi
  import gp_tlbi_pkg::*;
#(
  parameter int ENTRIES = 8
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic walk_req,
  input wire logic walk_level,
  input wire logic [PA_W-1:0] walk_addr,
  input wire logic walk_parent_ok,
  output logic fetch_req,
  output logic [PA_W-1:0] fetch_addr,
  input wire logic fill_valid,
  input wire fill_t fill,
  input wire logic peer_valid,
  input wire tlbi_msg_t peer_msg,
  output logic bcast_valid,
  output tlbi_msg_t bcast_msg
);
  localparam int PW = $clog2(ENTRIES);

  logic [31:0] cfg_reg;
  logic [31:0] tbase_reg;
  logic [31:0] oplo_reg;
  logic [31:0] ophi_reg;
  logic [3:0] stat_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [PW-1:0] rr_reg;
  tlb_entry_t ent_reg [ENTRIES];

  // bus strobes: a write lands on the edge where waitrequest is low
  logic acc;
  logic wr;
  logic [31:0] wmask;
  assign acc = (avs_read | avs_write) & ~wait_reg;
  assign wr = acc & avs_write;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (avs_writedata & wmask);
  endfunction

  // configuration views
  logic [1:0] phys_granule_size;
  logic [5:0] gsh;
  logic [5:0] pab;
  logic [5:0] ppsb;
  logic [5:0] l0s;
  logic [PA_W-1:0] tb_addr;
  logic cfg_ok;
  logic [PA_W-1:0] l0_span;
  assign phys_granule_size = cfg_reg[CFG_PGS +: 2];
  assign gsh = pgs_shift(phys_granule_size);
  assign pab = pa_bits(cfg_reg[CFG_PAR +: 3]);
  assign ppsb = pa_bits(cfg_reg[CFG_PPS +: 3]);
  assign l0s = l0_shift(cfg_reg[CFG_L0SZ +: 4]);
  assign tb_addr = {8'h00, tbase_reg, 12'h000};
  // configuration faults at first level: disabled, reserved CFG_PGS, CFG_PPS or CFG_L0SZ code, base too high
  assign cfg_ok = cfg_reg[CFG_EN] & (gsh != 6'h00) & (l0s != 6'h00)
                & (ppsb != 6'h00) & ((tb_addr >> ppsb) == '0);
  // first-level table holds one 8-byte entry per first-level span
  assign l0_span = (ppsb > l0s) ? (PA_W'(8) << (ppsb - l0s)) : PA_W'(8);

  // reachability of a table entry at address a
  function automatic logic reach(input logic lvl, input logic [PA_W-1:0] a,
                                 input logic parent);
    if (!lvl)
      reach = cfg_ok & (a >= tb_addr) & (a < tb_addr + l0_span);
    else
      reach = cfg_ok & parent;
  endfunction

  // decode a range operand against a granule code
  typedef struct packed {
    logic ok;
    logic [PA_W-1:0] base;
    logic [5:0] sh;
  } rng_t;

  function automatic rng_t dec_range(input logic [63:0] opd,
                                     input logic [1:0] g);
    rng_t r;
    logic [5:0] ps;
    logic [5:0] ss;
    logic [PA_W-1:0] lowm;
    ps = pgs_shift(g);
    ss = size_shift(opd[OPD_SIZE +: 4]);
    r.sh = (ss < ps) ? ps : ss;
    lowm = (PA_W'(1) << ps) - PA_W'(1);
    r.base = (PA_W'(opd[OPD_ADDR_W-1:0]) << GRAN_LSB) & ~lowm;
    lowm = (PA_W'(1) << r.sh) - PA_W'(1);
    r.ok = (ps != 6'h00)
         & (ss != 6'h00)
         & ((r.base & lowm) == '0)
         & ((r.base >> pab) == '0);
    return r;
  endfunction

  // decode the instruction fields of a command word
  function automatic op_t dec_op(input logic [31:0] c);
    op_t o;
    o = OP_NONE;
    if (c[CMD_OP0 +: 2] == ENC_OP0 && c[CMD_OP1 +: 3] == ENC_OP1
        && c[CMD_CRN +: 4] == ENC_CRN)
    begin
      if (c[CMD_CRM +: 4] == CRM_RANGE && c[CMD_OP2 +: 3] == OP2_ANY)
        o = OP_RANGE_ANY;
      else if (c[CMD_CRM +: 4] == CRM_RANGE && c[CMD_OP2 +: 3] == OP2_LAST)
        o = OP_RANGE_LAST;
      else if (c[CMD_CRM +: 4] == CRM_ALL_OS && c[CMD_OP2 +: 3] == OP2_ALL)
        o = OP_ALL_SHARED;
      else if (c[CMD_CRM +: 4] == CRM_ALL_LOC && c[CMD_OP2 +: 3] == OP2_ALL)
        o = OP_ALL_LOCAL;
    end
    return o;
  endfunction

  // local command issue
  logic [31:0] cmd_word;
  op_t cmd_op;
  logic cmd_go;
  logic priv_ok;
  op_t loc_op;
  logic [63:0] loc_opd;
  rng_t loc_rng;
  assign cmd_word = avs_writedata & wmask;
  assign cmd_op = dec_op(cmd_word);
  assign cmd_go = wr & (avs_address == OFF_CMD);
  assign priv_ok = cmd_word[CMD_EL +: 2] == TOP_PRIV;
  assign loc_op = (cmd_go & priv_ok) ? cmd_op : OP_NONE;
  assign loc_opd = {ophi_reg, oplo_reg};
  // procedural so that a change of the implemented address size re-decodes too
  always_comb
  begin
    loc_rng = dec_range(loc_opd, phys_granule_size);
  end

  // received broadcast; mismatched granule drops range work here
  op_t rx_op;
  rng_t rx_rng;
  logic rx_rng_ok;
  assign rx_op = peer_valid ? peer_msg.op : OP_NONE;
  // procedural for the same reason as the local decode
  always_comb
  begin
    rx_rng = dec_range(peer_msg.operand, phys_granule_size);
  end
  assign rx_rng_ok = rx_rng.ok & (peer_msg.phys_granule_size == phys_granule_size);

  logic loc_all;
  logic rx_all;
  logic loc_is_rng;
  assign loc_all = (loc_op == OP_ALL_SHARED) | (loc_op == OP_ALL_LOCAL);
  assign rx_all = (rx_op == OP_ALL_SHARED) | (rx_op == OP_ALL_LOCAL);
  assign loc_is_rng = (loc_op == OP_RANGE_ANY) | (loc_op == OP_RANGE_LAST);

  // range hit on one entry; aligned regions overlap when equal above the larger size
  function automatic logic rng_hit(input tlb_entry_t e, input op_t o,
                                   input rng_t r);
    logic [5:0] m;
    m = (r.sh > e.shift) ? r.sh : e.shift;
    rng_hit = r.ok & ((e.addr >> m) == (r.base >> m))
            & ((o == OP_RANGE_ANY) | (o == OP_RANGE_LAST & e.level));
  endfunction

  // per entry kill and parent lookup
  logic [ENTRIES-1:0] kill;
  logic [ENTRIES-1:0] l0_walk;
  logic [ENTRIES-1:0] l0_fill;
  logic fill_ok;
  // procedural so that table base and configuration changes are seen at once
  always_comb
  begin
    fill_ok = fill_valid & fill.desc_ok
            & reach(fill.level, fill.addr, fill.parent_ok | (|l0_fill));
  end

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++)
    begin : g_ent
      tlb_entry_t e;
      assign e = ent_reg[gi];
      // lock and merge bits never shield an entry from invalidation
      assign kill[gi] = e.valid & (loc_all | rx_all
                      | rng_hit(e, loc_op, loc_rng)
                      | (rx_rng_ok & rng_hit(e, rx_op, rx_rng)));
      // a cached fault-free first-level entry still points down
      assign l0_walk[gi] = e.valid & ~e.level
                         & ((e.addr >> e.shift) == (walk_addr >> e.shift));
      assign l0_fill[gi] = e.valid & ~e.level
                         & ((e.addr >> e.shift) == (fill.addr >> e.shift));

      // entry storage: a fill into this slot lands after the kill
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          ent_reg[gi] <= '0;
        else if (fill_ok && rr_reg == PW'(gi))
          ent_reg[gi] <= '{valid: 1'b1, level: fill.level, addr: fill.addr,
                           shift: fill.shift, merged: fill.merged,
                           lock: fill.lock};
        else if (kill[gi])
          ent_reg[gi].valid <= 1'b0;
      end
    end
  endgenerate

  // replacement pointer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rr_reg <= '0;
    else if (fill_ok)
      rr_reg <= (rr_reg == PW'(ENTRIES - 1)) ? '0 : rr_reg + PW'(1);
  end

  // walk fetch gate
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fetch_req <= 1'b0;
      fetch_addr <= '0;
    end
    else
    begin
      fetch_req <= walk_req
                 & reach(walk_level, walk_addr, walk_parent_ok | (|l0_walk));
      fetch_addr <= walk_addr;
    end
  end

  // broadcast of shared-scope operations; local-all stays here
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bcast_valid <= 1'b0;
      bcast_msg <= '{op: OP_NONE, operand: '0, phys_granule_size: '0};
    end
    else
    begin
      bcast_valid <= loc_is_rng | (loc_op == OP_ALL_SHARED);
      if (loc_op != OP_NONE)
        bcast_msg <= '{op: loc_op, operand: loc_opd, phys_granule_size: phys_granule_size};
    end
  end

  // configuration registers; peers may differ and each follows its own copy
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_reg <= CFG_RST;
      tbase_reg <= TBASE_RST;
      oplo_reg <= '0;
      ophi_reg <= '0;
    end
    else if (wr)
    begin
      if (avs_address == OFF_CFG)
        cfg_reg <= merge(cfg_reg);
      if (avs_address == OFF_TBASE)
        tbase_reg <= merge(tbase_reg);
      if (avs_address == OFF_OPLO)
        oplo_reg <= merge(oplo_reg);
      if (avs_address == OFF_OPHI)
        ophi_reg <= merge(ophi_reg);
    end
  end

  // sticky status; a write of one clears all but ST_CFGC, which an invalidate-all clears; a new event in that cycle wins
  logic [3:0] st_set;
  logic [3:0] st_clr;
  assign st_set[ST_UNDEF] = cmd_go & ~priv_ok & (cmd_op != OP_NONE);
  assign st_set[ST_UNKNOWN] = cmd_go & (cmd_op == OP_NONE);
  assign st_set[ST_CFGC] = fill_ok;
  assign st_set[ST_SKIP] = loc_is_rng & ~loc_rng.ok;
  assign st_clr[ST_UNDEF] = wr & (avs_address == OFF_STAT)
                          & cmd_word[ST_UNDEF];
  assign st_clr[ST_UNKNOWN] = wr & (avs_address == OFF_STAT)
                            & cmd_word[ST_UNKNOWN];
  assign st_clr[ST_CFGC] = loc_all | rx_all;
  assign st_clr[ST_SKIP] = wr & (avs_address == OFF_STAT)
                         & cmd_word[ST_SKIP];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      stat_reg <= '0;
    else
      stat_reg <= st_set | (stat_reg & ~st_clr);
  end

  // valid map for readback
  logic [31:0] vmap;
  always_comb
  begin
    vmap = '0;
    for (int i = 0; i < ENTRIES && i < 32; i++)
      vmap[i] = ent_reg[i].valid;
  end

  // bus handshake: one wait cycle, read data registered on the first edge
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wait_reg <= 1'b1;
    else if ((avs_read | avs_write) & wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_reg <= '0;
    else if (avs_read & wait_reg)
    begin
      case (avs_address)
        OFF_CFG: rdata_reg <= cfg_reg;
        OFF_TBASE: rdata_reg <= tbase_reg;
        OFF_OPLO: rdata_reg <= oplo_reg;
        OFF_OPHI: rdata_reg <= ophi_reg;
        OFF_STAT: rdata_reg <= {28'h0000000, stat_reg};
        OFF_VALID: rdata_reg <= vmap;
        default: rdata_reg <= '0; // unmapped and command read as zero
      endcase
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
endmodule
`default_nettype wire

// >>> rtl/gp_tlbi_pkg.sv
// package for the protection-table tlb invalidation block
// holds register map, field positions, encodings and size decoders
package gp_tlbi_pkg;
  localparam int PA_W = 52;
  localparam int AW = 5;
  // register byte offsets
  localparam logic [4:0] OFF_CFG = 5'h00;
  localparam logic [4:0] OFF_TBASE = 5'h04;
  localparam logic [4:0] OFF_OPLO = 5'h08;
  localparam logic [4:0] OFF_OPHI = 5'h0C;
  localparam logic [4:0] OFF_CMD = 5'h10;
  localparam logic [4:0] OFF_STAT = 5'h14;
  localparam logic [4:0] OFF_VALID = 5'h18;
  // reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] TBASE_RST = 32'h0000_0000;
  // protection_config_reg fields
  localparam int CFG_EN = 0;
  localparam int CFG_PGS = 1;
  localparam int CFG_PPS = 4;
  localparam int CFG_L0SZ = 8;
  localparam int CFG_PAR = 12;
  // command register fields
  localparam int CMD_OP0 = 0;
  localparam int CMD_OP1 = 2;
  localparam int CMD_CRN = 5;
  localparam int CMD_CRM = 9;
  localparam int CMD_OP2 = 13;
  localparam int CMD_EL = 16;
  localparam logic [1:0] TOP_PRIV = 2'h3;
  // status register fields
  localparam int ST_UNDEF = 0;
  localparam int ST_UNKNOWN = 1;
  localparam int ST_CFGC = 2;
  localparam int ST_SKIP = 3;
  // system instruction encodings
  localparam logic [1:0] ENC_OP0 = 2'h1;
  localparam logic [2:0] ENC_OP1 = 3'h6;
  localparam logic [3:0] ENC_CRN = 4'h8;
  localparam logic [3:0] CRM_RANGE = 4'h4;
  localparam logic [2:0] OP2_ANY = 3'h3;
  localparam logic [2:0] OP2_LAST = 3'h7;
  localparam logic [3:0] CRM_ALL_OS = 4'h1;
  localparam logic [3:0] CRM_ALL_LOC = 4'h7;
  localparam logic [2:0] OP2_ALL = 3'h4;
  // operand fields
  localparam int OPD_SIZE = 44;
  localparam int OPD_ADDR_W = 40;
  localparam int GRAN_LSB = 12;

  typedef enum logic [2:0] {
    OP_NONE, OP_RANGE_ANY, OP_RANGE_LAST, OP_ALL_SHARED, OP_ALL_LOCAL
  } op_t;

  typedef struct packed {
    op_t op;
    logic [63:0] operand;
    logic [1:0] phys_granule_size;
  } tlbi_msg_t;

  typedef struct packed {
    logic level;
    logic [PA_W-1:0] addr;
    logic [5:0] shift;
    logic desc_ok;
    logic parent_ok;
    logic merged;
    logic lock;
  } fill_t;

  typedef struct packed {
    logic valid;
    logic level;
    logic [PA_W-1:0] addr;
    logic [5:0] shift;
    logic merged;
    logic lock;
  } tlb_entry_t;

  // granule size code to log2 bytes, zero when reserved
  function automatic logic [5:0] pgs_shift(input logic [1:0] c);
    case (c)
      2'h0: pgs_shift = 6'h0C;
      2'h2: pgs_shift = 6'h0E;
      2'h1: pgs_shift = 6'h10;
      default: pgs_shift = 6'h00;
    endcase
  endfunction

  // range size code to log2 bytes, zero when reserved
  function automatic logic [5:0] size_shift(input logic [3:0] c);
    case (c)
      4'h0: size_shift = 6'h0C;
      4'h1: size_shift = 6'h0E;
      4'h2: size_shift = 6'h10;
      4'h3: size_shift = 6'h15;
      4'h4: size_shift = 6'h19;
      4'h5: size_shift = 6'h1D;
      4'h6: size_shift = 6'h1E;
      4'h7: size_shift = 6'h22;
      4'h8: size_shift = 6'h24;
      4'h9: size_shift = 6'h27;
      default: size_shift = 6'h00;
    endcase
  endfunction

  // physical address size code to bits, zero when reserved
  function automatic logic [5:0] pa_bits(input logic [2:0] c);
    case (c)
      3'h0: pa_bits = 6'h20;
      3'h1: pa_bits = 6'h24;
      3'h2: pa_bits = 6'h28;
      3'h3: pa_bits = 6'h2A;
      3'h4: pa_bits = 6'h2C;
      3'h5: pa_bits = 6'h30;
      3'h6: pa_bits = 6'h34;
      default: pa_bits = 6'h00;
    endcase
  endfunction

  // first-level entry span code to log2 bytes
  function automatic logic [5:0] l0_shift(input logic [3:0] c);
    case (c)
      4'h0: l0_shift = 6'h1E;
      4'h4: l0_shift = 6'h22;
      4'h6: l0_shift = 6'h24;
      4'h9: l0_shift = 6'h27;
      default: l0_shift = 6'h00;
    endcase
  endfunction
endpackage

// >>> verification/gp_tlbi_properties.sv
// concurrent checks on the ports of the protection-table tlb block
// bound into the design top from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module gp_tlbi_properties
  import gp_tlbi_pkg::*;
#(
  parameter int ENTRIES = 8
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic walk_req,
  input wire logic walk_level,
  input wire logic [PA_W-1:0] walk_addr,
  input wire logic walk_parent_ok,
  input wire logic fetch_req,
  input wire logic [PA_W-1:0] fetch_addr,
  input wire logic fill_valid,
  input wire fill_t fill,
  input wire logic peer_valid,
  input wire tlbi_msg_t peer_msg,
  input wire logic bcast_valid,
  input wire tlbi_msg_t bcast_msg
);
  logic cmd_taken;
  logic cmd_d;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // command write accepted this cycle, and one cycle late
  assign cmd_taken = avs_write && !avs_waitrequest && avs_address == OFF_CMD;
  always_ff @(posedge ref_clk)
  begin
    cmd_d <= rst ? 1'b0 : cmd_taken;
  end
  sequence s_low_el;
    cmd_taken && avs_writedata[CMD_EL +: 2] != TOP_PRIV;
  endsequence
  sequence s_shared_all;
    cmd_taken && avs_writedata == {14'h0, TOP_PRIV, OP2_ALL, CRM_ALL_OS, ENC_CRN, ENC_OP1, ENC_OP0};
  endsequence
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_read_zero;
    avs_read && !avs_waitrequest && (avs_address == OFF_CMD || avs_address > OFF_VALID)
      |-> avs_readdata == 32'h0;
  endproperty
  property p_fetch_cause;
    fetch_req |-> $past(walk_req);
  endproperty
  property p_fetch_addr;
    fetch_req |-> fetch_addr == $past(walk_addr);
  endproperty
  property p_bcast_cause;
    bcast_valid |-> cmd_d && bcast_msg.op != OP_ALL_LOCAL;
  endproperty
  property p_bcast_pulse;
    bcast_valid |=> !bcast_valid;
  endproperty
  property p_bcast_shared;
    s_shared_all |=> bcast_valid && bcast_msg.op == OP_ALL_SHARED;
  endproperty
  property p_low_el_quiet;
    s_low_el |=> !bcast_valid;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after one wait");
  a_wait_one: assert property (p_wait_one) else $error("wait low longer than a cycle");
  a_read_zero: assert property (p_read_zero) else $error("nonzero read of empty place");
  a_fetch_cause: assert property (p_fetch_cause) else $error("fetch without walk");
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
  a_bcast_cause: assert property (p_bcast_cause) else $error("stray broadcast");
  a_bcast_pulse: assert property (p_bcast_pulse) else $error("broadcast too long");
  a_bcast_shared: assert property (p_bcast_shared) else $error("shared op not sent");
  a_low_el_quiet: assert property (p_low_el_quiet) else $error("low level op sent");
endmodule
`default_nettype wire

// >>> verification/gp_tlbi_test.sv
// self-checking bench for the protection-table tlb block
// assumes the package, checker and peer model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH at %0t: got %h expected %h", $time, (a), (e)); end end
module gp_tlbi_test;
  import gp_tlbi_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic walk_req = 1'b0;
  logic walk_level = 1'b0;
  logic [PA_W-1:0] walk_addr = '0;
  logic walk_parent_ok = 1'b0;
  logic fetch_req;
  logic [PA_W-1:0] fetch_addr;
  logic fill_valid = 1'b0;
  fill_t fill = '0;
  logic send = 1'b0;
  tlbi_msg_t send_msg = '0;
  logic peer_valid;
  tlbi_msg_t peer_msg;
  logic bcast_valid;
  tlbi_msg_t bcast_msg;
  logic [7:0] rx_count;
  logic [31:0] rd;
  logic [31:0] skip_lo [3] = '{32'h200, 32'h100, 32'h0};
  logic [31:0] skip_hi [3] = '{32'hA000, 32'h3000, 32'h80};
  int fail_count = 0;
  int comparisons = 0;
  gp_tlbi #(.ENTRIES(8)) dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .walk_req(walk_req), .walk_level(walk_level), .walk_addr(walk_addr),
    .walk_parent_ok(walk_parent_ok), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fill_valid(fill_valid), .fill(fill), .peer_valid(peer_valid), .peer_msg(peer_msg),
    .bcast_valid(bcast_valid), .bcast_msg(bcast_msg));
  peer_tlb_model peer (.ref_clk(ref_clk), .rst(rst), .send(send), .send_msg(send_msg),
    .bcast_valid(bcast_valid), .peer_valid(peer_valid), .peer_msg(peer_msg),
    .rx_count(rx_count));
  // free-running clock
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 64)
    begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  function automatic logic [31:0] cmd(input logic [3:0] crm, input logic [2:0] op2,
    input logic [1:0] el);
    return {14'h0, el, op2, crm, ENC_CRN, ENC_OP1, ENC_OP0};
  endfunction
  task automatic rng(input logic [31:0] lo, input logic [31:0] hi, input logic [2:0] op2);
    wr(OFF_OPLO, lo);
    wr(OFF_OPHI, hi);
    wr(OFF_CMD, cmd(CRM_RANGE, op2, TOP_PRIV));
  endtask
  // one walker request, fetch checked half a cycle after it lands
  task automatic walk(input logic l, input logic [PA_W-1:0] a, input logic p, input logic e);
    @(posedge ref_clk);
    walk_req <= 1'b1;
    walk_level <= l;
    walk_addr <= a;
    walk_parent_ok <= p;
    @(posedge ref_clk);
    walk_req <= 1'b0;
    walk_addr <= ~a;
    @(negedge ref_clk);
    `CHK(fetch_req, e)
    if (e)
      `CHK(fetch_addr, a)
  endtask
  task automatic fl(input logic l, input logic [PA_W-1:0] a, input logic [5:0] s, input logic ok,
    input logic p);
    @(posedge ref_clk);
    fill_valid <= 1'b1;
    fill <= '{l, a, s, ok, p, 1'b1, 1'b1};
    @(posedge ref_clk);
    fill_valid <= 1'b0;
  endtask
  task automatic pr(input op_t op, input logic [31:0] lo, input logic [1:0] g);
    @(posedge ref_clk);
    send <= 1'b1;
    send_msg <= '{op, {32'h0, lo}, g};
    @(posedge ref_clk);
    send <= 1'b0;
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(OFF_CFG, CFG_RST);
    rdc(OFF_TBASE, TBASE_RST);
    rdc(OFF_STAT, 32'h0);
    rdc(OFF_CMD, 32'h0);
    rdc(5'h1C, 32'h0);
    $display("test reset done");
    wr(OFF_CFG, 32'h0000_4001);
    wr(OFF_TBASE, 32'h0000_0100);
    walk(1'b0, 52'h100000, 1'b0, 1'b1);
    walk(1'b0, 52'h100018, 1'b0, 1'b1);
    walk(1'b0, 52'h100020, 1'b0, 1'b0);
    walk(1'b0, 52'h0FFFF8, 1'b0, 1'b0);
    walk(1'b1, 52'h300000, 1'b0, 1'b0);
    walk(1'b1, 52'h300000, 1'b1, 1'b1);
    $display("test walk gate done");
    fl(1'b1, 52'h100000, 6'h0C, 1'b0, 1'b1);
    fl(1'b1, 52'h200000, 6'h15, 1'b1, 1'b0);
    rdc(OFF_VALID, 32'h0);
    fl(1'b0, 52'h100000, 6'h0C, 1'b1, 1'b0);
    fl(1'b1, 52'h100000, 6'h0C, 1'b1, 1'b1);
    fl(1'b1, 52'h200000, 6'h15, 1'b1, 1'b1);
    rdc(OFF_VALID, 32'h7);
    rdc(OFF_STAT, 32'h4);
    rng(32'h100, 32'h0, OP2_LAST);
    rdc(OFF_VALID, 32'h5);
    rng(32'h100, 32'h0, OP2_ANY);
    rdc(OFF_VALID, 32'h4);
    `CHK(bcast_msg.op, OP_RANGE_ANY)
    `CHK(bcast_msg.operand, 64'h100)
    `CHK(bcast_msg.phys_granule_size, 2'h0)
    $display("test range levels done");
    for (int i = 0; i < 3; i++)
    begin
      rng(skip_lo[i], skip_hi[i], OP2_ANY);
      rdc(OFF_VALID, 32'h4);
      rdc(OFF_STAT, 32'hC);
      wr(OFF_STAT, 32'h8);
    end
    rng(32'h200, 32'h3000, OP2_LAST);
    rdc(OFF_VALID, 32'h0);
    `CHK(rx_count, 8'h06)
    $display("test range skips done");
    fl(1'b1, 52'h500000, 6'h0C, 1'b1, 1'b1);
    wr(OFF_CMD, cmd(CRM_ALL_LOC, OP2_ALL, 2'h2));
    rdc(OFF_STAT, 32'h5);
    rdc(OFF_VALID, 32'h8);
    wr(OFF_STAT, 32'h1);
    wr(OFF_CMD, cmd(4'h2, OP2_ALL, TOP_PRIV));
    rdc(OFF_STAT, 32'h6);
    wr(OFF_STAT, 32'h2);
    wr(OFF_CMD, cmd(CRM_ALL_LOC, OP2_ALL, TOP_PRIV));
    rdc(OFF_VALID, 32'h0);
    rdc(OFF_STAT, 32'h0);
    `CHK(rx_count, 8'h06)
    fl(1'b1, 52'h600000, 6'h0C, 1'b1, 1'b1);
    wr(OFF_CMD, cmd(CRM_ALL_OS, OP2_ALL, TOP_PRIV));
    rdc(OFF_VALID, 32'h0);
    `CHK(rx_count, 8'h07)
    `CHK(bcast_msg.op, OP_ALL_SHARED)
    $display("test invalidate all done");
    wr(OFF_CFG, 32'h0000_4005);
    fl(1'b1, 52'h400000, 6'h0E, 1'b1, 1'b1);
    rdc(OFF_VALID, 32'h20);
    rng(32'h401, 32'h0, OP2_ANY);
    rdc(OFF_VALID, 32'h0);
    $display("test granule base done");
    fl(1'b1, 52'h400000, 6'h0E, 1'b1, 1'b1);
    pr(OP_RANGE_ANY, 32'h400, 2'h0);
    rdc(OFF_VALID, 32'h40);
    pr(OP_RANGE_ANY, 32'h400, 2'h2);
    rdc(OFF_VALID, 32'h0);
    fl(1'b1, 52'h700000, 6'h0C, 1'b1, 1'b1);
    pr(OP_ALL_SHARED, 32'h0, 2'h2);
    rdc(OFF_VALID, 32'h0);
    `CHK(rx_count, 8'h08)
    $display("test peer messages done");
    end_sim();
  end
endmodule
bind gp_tlbi gp_tlbi_properties #(.ENTRIES(ENTRIES)) props (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .walk_req(walk_req),
  .walk_level(walk_level), .walk_addr(walk_addr), .walk_parent_ok(walk_parent_ok),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fill_valid(fill_valid), .fill(fill),
  .peer_valid(peer_valid), .peer_msg(peer_msg), .bcast_valid(bcast_valid),
  .bcast_msg(bcast_msg));
`undef CHK
`default_nettype wire

// >>> verification/peer_tlb_model.sv
// peer tlb model: sends broadcast invalidations in, counts the block's own
// assumes the bench raises send for one cycle per message
`timescale 1ns/1ps
`default_nettype none
module peer_tlb_model
  import gp_tlbi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic send,
  input wire tlbi_msg_t send_msg,
  input wire logic bcast_valid,
  output logic peer_valid,
  output tlbi_msg_t peer_msg,
  output logic [7:0] rx_count
);
  // one-cycle message, reserved operand bits zero; lines toggle between sends
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      peer_valid <= 1'b0;
      peer_msg <= '0;
      rx_count <= 8'h00;
    end
    else
    begin
      peer_valid <= send;
      if (send)
        peer_msg <= '{send_msg.op, send_msg.operand & 64'h0000_F0FF_FFFF_FFFF, send_msg.phys_granule_size};
      else
        peer_msg <= ~peer_msg;
      if (bcast_valid)
        rx_count <= rx_count + 8'h01;
    end
  end
endmodule
`default_nettype wire
